/* File: shifter_bitfifo_regs.vh */
`ifndef SHIFTER_BITFIFO_REGS_VH
`define SHIFTER_BITFIFO_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_COMMAND 8'h00
`define OFS_SOURCE 8'h04
`define OFS_LENGTH 8'h08
`define OFS_RESULT 8'h0C
`define OFS_STATUS 8'h10
`define OFS_WRPTR 8'h14
`define OFS_FIFO_HI 8'h18
`define OFS_FIFO_LO 8'h1C

// ----------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------
`define CMD_OP_MSB 2
`define CMD_OP_LSB 0
`define CMD_NO_UPDATE 3
`define CMD_USE_IMM 4
`define CMD_IMM_MSB 27
`define CMD_IMM_LSB 16

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define OP_EXP_ADDER 3'h0
`define OP_LEAD_ZEROS 3'h1
`define OP_LEAD_ONES 3'h2
`define OP_PACK 3'h3
`define OP_UNPACK 3'h4
`define OP_DEPOSIT 3'h5
`define OP_EXTRACT 3'h6
`define OP_SET_WRPTR 3'h7

// ----------------------------------------------------------------
// status register bit positions and reset values
// ----------------------------------------------------------------
`define ST_SIGN 0
`define ST_ZERO 1
`define ST_OVF 2
`define ST_FILL 3
`define RST_RESULT 32'h00000000
`define RST_FIFO 64'h0000000000000000
`define RST_WRPTR 7'h00

// ----------------------------------------------------------------
// numeric limits
// ----------------------------------------------------------------
`define MAX_LEN 6'h20
`define FIFO_BITS 8'h40
`define FILL_LEVEL 7'h20
`define MAX_WRPTR 7'h40
`define PACK_SAT_EXP 8'h87
`define PACK_NORM_EXP 8'h78
`define PACK_MIN_EXP 8'h6E
`define UNPACK_DEN_EXP 8'h78

`endif

/* File: shifter_exponent_pack_bitfifo.v */
`timescale 1ns/100ps
`include "shifter_bitfifo_regs.vh"

// What this block does
// - adder-exponent op with adder overflow set writes +1 as shift count.
// - otherwise shift count is minus (leading sign bits minus one).
// - adder-exponent sign flag is adder overflow XOR source bit 31.
// - adder-exponent zero flag set when exponent is 0; overflow flag cleared.
// - leading-zero count goes to bit position field; sign flag cleared.
// - leading zeros: zero flag on top bit one, overflow flag on count 32.
// - leading ones: zero flag on top bit zero, overflow on 32, sign cleared.
// - pack float to 16-bit sign, 4-bit exponent, fraction; sign kept.
// - pack exponent above 135 gives largest magnitude of same sign.
// - exponent 121..135 packs top and three low exponent bits, rounded fraction.
// - exponent 110..120 packs zero exponent and rounded shifted denormal fraction.
// - exponent below 110 packs zero apart from the sign.
// - unpack nonzero exponent rebuilds eight-bit exponent, fraction padded by 12 zeros.
// - unpack zero exponent, nonzero fraction gives 120 minus leading zeros, normalised fraction.
// - deposit ORs low length source bits just below the occupied fifo bits.
// - deposit advances write pointer by length from register or immediate.
// - deposit length over 32 or overflowing space sets overflow; sign, zero cleared.
// - fill flag set when updated write pointer is at least 32.
// - extract returns top length bits, shifts fifo left, lowers pointer.
// - no-update extract keeps fifo, pointer and fill flag unchanged.
// - extract length over 32 or beyond content sets overflow, else cleared.
// - extract zero flag follows returned value; sign flag cleared.
// - direct pointer write loads low 7 bits; above 64 sets overflow.
module shifter_exponent_pack_bitfifo #(
    parameter ADDR_W = 8,
    parameter DATA_W = 32
) (
    input wire mclk,
    input wire rst_n,
    input wire [ADDR_W-1:0] regAddr,
    input wire [DATA_W-1:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [DATA_W-1:0] regRdata,
    input wire adderOverflowFlag,
    output reg shifterSignFlag,
    output reg shifterZeroFlag,
    output reg shifterOverflowFlag,
    output reg fifoFillFlag
);

// ----------------------------------------------------------------
// reset synchroniser
// ----------------------------------------------------------------
reg rstMeta_r;
reg rstSync_r;

// release is synchronous, assertion stays asynchronous
// a short pulse clears both stages, so no stale release survives it
always @(posedge mclk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rstMeta_r <= 1'b0;
        rstSync_r <= 1'b0;
    end
    else
    begin
        rstMeta_r <= 1'b1;
        rstSync_r <= rstMeta_r;
    end
end

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [5:0] clz32;
    input [31:0] v;
    integer i;
    reg done;
    begin
        clz32 = 6'h00;
        done = 1'b0;
        for (i = 31; i >= 0; i = i - 1)
        begin
            if (!done)
            begin
                if (v[i])
                    done = 1'b1;
                else
                    clz32 = clz32 + 6'h01;
            end
        end
    end
endfunction

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
// operand registers source_r and length_r, written over the bus ahead of the command; then result, fifo and pointer state
reg [31:0] source_r;
reg [31:0] length_r;
reg [31:0] result_r;
reg [63:0] bitFifoStore_r;
reg [6:0] wrPtr_r;
// next values, worked out by the execute process below
reg [31:0] resultNxt;
reg [63:0] bitFifoNxt;
reg [6:0] wrPtrNxt;
reg signNxt;
reg zeroNxt;
reg ovfNxt;
reg fillNxt;

// command decode; a command write executes in the cycle it is taken
// operands come from the stored registers, so write them a cycle ahead
wire cmdWr = regWr && (regAddr == `OFS_COMMAND);
wire [2:0] opCode = regWdata[`CMD_OP_MSB:`CMD_OP_LSB];
wire noUpdateModifier = regWdata[`CMD_NO_UPDATE];
wire [11:0] lengthImmediate = regWdata[`CMD_IMM_MSB:`CMD_IMM_LSB];
// only the low six length bits take part, wider values are prohibited
wire [5:0] bitLen = regWdata[`CMD_USE_IMM] ? lengthImmediate[5:0] : length_r[5:0];
wire lenBad = bitLen > `MAX_LEN;

// ----------------------------------------------------------------
// exponent and leading-bit counts
// ----------------------------------------------------------------
wire [5:0] signRun = clz32(source_r[31] ? ~source_r : source_r);
wire [7:0] adderExp = adderOverflowFlag ? 8'h01
                    : (8'h01 - {2'b00, signRun});
wire [5:0] leadZeros = clz32(source_r);
wire [5:0] leadOnes = clz32(~source_r);

// ----------------------------------------------------------------
// short float pack
// ----------------------------------------------------------------
wire [7:0] packExp = source_r[30:23];
wire [22:0] packFrac = source_r[22:0];
wire [7:0] denShift = `PACK_NORM_EXP - packExp;
wire [23:0] denMant = {1'b1, packFrac} >> denShift[4:0];
// rounding carries into the exponent, which is the right carry for both ranges
wire [15:0] normSum = {1'b0, packExp[7], packExp[2:0], packFrac[22:12]}
                    + {15'h0000, packFrac[11]};
wire [15:0] denSum = {5'h00, denMant[23:13]} + {15'h0000, denMant[12]};
reg [14:0] packBody;

// pick the packed exponent and fraction by source exponent range
always @*
begin
    if (packExp > `PACK_SAT_EXP)
        packBody = 15'h7FFF;
    else if (packExp > `PACK_NORM_EXP)
        packBody = normSum[15] ? 15'h7FFF : normSum[14:0];
    else if (packExp >= `PACK_MIN_EXP)
        packBody = denSum[14:0];
    else
        packBody = 15'h0000;
end
wire [31:0] packWord = {16'h0000, source_r[31], packBody};

// ----------------------------------------------------------------
// short float unpack
// ----------------------------------------------------------------
wire [3:0] upExp = source_r[14:11];
wire [10:0] upFrac = source_r[10:0];
wire [5:0] upZeros = clz32({upFrac, 21'h00000});
wire [10:0] upNorm = upFrac << (upZeros + 6'h01);
wire [7:0] upDenExp = `UNPACK_DEN_EXP - {2'b00, upZeros};
// top bit first, then its inverse four times, re-biases the short exponent
wire [7:0] upFullExp = {upExp[3], {4{~upExp[3]}}, upExp[2:0]};
reg [30:0] unpackBody;

// with a zero exponent, a zero fraction has no hidden one to find, so it unpacks to signed zero
always @*
begin
    if (upExp != 4'h0)
        unpackBody = {upFullExp, upFrac, 12'h000};
    else if (upFrac == 11'h000)
        unpackBody = 31'h00000000;
    else
        unpackBody = {upDenExp, upNorm, 12'h000};
end
wire [31:0] unpackWord = {source_r[15], unpackBody};

// ----------------------------------------------------------------
// bit fifo
// ----------------------------------------------------------------
// deposit lands just below the occupied bits, counted from the top
wire [7:0] depSum = {1'b0, wrPtr_r} + {2'b00, bitLen};
wire [7:0] depShift = `FIFO_BITS - depSum;
wire [63:0] lowMask = ~({64{1'b1}} << bitLen);
wire [63:0] depBits = ({32'h00000000, source_r} & lowMask) << depShift[6:0];
// a zero length would need a full 32-bit shift, so it is forced to zero
wire [5:0] extShift = `MAX_LEN - bitLen;
wire [31:0] extVal = (bitLen == 6'h00) ? 32'h00000000
                   : (bitFifoStore_r[63:32] >> extShift);
// asking for more bits than stored is flagged; the fifo then goes undefined
wire extUnder = {1'b0, bitLen} > wrPtr_r;
wire [6:0] extPtr = wrPtr_r - {1'b0, bitLen};
wire [6:0] newPtr = source_r[6:0];

// ----------------------------------------------------------------
// operation execute
// ----------------------------------------------------------------
// every operation rewrites the shared flags together; fill only where due
always @*
begin
    resultNxt = result_r;
    bitFifoNxt = bitFifoStore_r;
    wrPtrNxt = wrPtr_r;
    signNxt = shifterSignFlag;
    zeroNxt = shifterZeroFlag;
    ovfNxt = shifterOverflowFlag;
    fillNxt = fifoFillFlag;
    if (cmdWr)
    begin
        case (opCode)
            `OP_EXP_ADDER:
            begin
                resultNxt = {24'h000000, adderExp};
                signNxt = adderOverflowFlag ^ source_r[31];
                zeroNxt = (adderExp == 8'h00);
                ovfNxt = 1'b0;
            end
            `OP_LEAD_ZEROS:
            begin
                resultNxt = {26'h0000000, leadZeros};
                signNxt = 1'b0;
                zeroNxt = source_r[31];
                ovfNxt = (leadZeros == `MAX_LEN);
            end
            `OP_LEAD_ONES:
            begin
                resultNxt = {26'h0000000, leadOnes};
                signNxt = 1'b0;
                zeroNxt = ~source_r[31];
                ovfNxt = (leadOnes == `MAX_LEN);
            end
            // neither conversion overflows: out-of-range inputs saturate or flush
            `OP_PACK, `OP_UNPACK:
            begin
                resultNxt = (opCode == `OP_PACK) ? packWord : unpackWord;
                signNxt = 1'b0;
                zeroNxt = 1'b0;
                ovfNxt = 1'b0;
            end
            `OP_DEPOSIT:
            begin
                // an overflowing deposit still runs; its outcome is undefined
                bitFifoNxt = bitFifoStore_r | depBits;
                wrPtrNxt = depSum[6:0];
                signNxt = 1'b0;
                zeroNxt = 1'b0;
                ovfNxt = lenBad || (depSum > {1'b0, `MAX_WRPTR});
                fillNxt = (depSum[6:0] >= `FILL_LEVEL);
            end
            `OP_EXTRACT:
            begin
                resultNxt = extVal;
                signNxt = 1'b0;
                zeroNxt = (extVal == 32'h00000000);
                ovfNxt = lenBad || extUnder;
                if (!noUpdateModifier)
                begin
                    bitFifoNxt = bitFifoStore_r << bitLen;
                    wrPtrNxt = extPtr;
                    fillNxt = (extPtr >= `FILL_LEVEL);
                end
            end
            `OP_SET_WRPTR:
            begin
                wrPtrNxt = newPtr;
                signNxt = 1'b0;
                zeroNxt = 1'b0;
                ovfNxt = (newPtr > `MAX_WRPTR);
                fillNxt = (newPtr >= `FILL_LEVEL);
            end
            default:
            begin
                resultNxt = result_r;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// registers and status flags
// ----------------------------------------------------------------
// flags are the status bits that the core sees for this element
always @(posedge mclk or negedge rstSync_r)
begin
    if (!rstSync_r)
    begin
        source_r <= 32'h00000000;
        length_r <= 32'h00000000;
        result_r <= `RST_RESULT;
        bitFifoStore_r <= `RST_FIFO;
        wrPtr_r <= `RST_WRPTR;
        shifterSignFlag <= 1'b0;
        shifterZeroFlag <= 1'b0;
        shifterOverflowFlag <= 1'b0;
        fifoFillFlag <= 1'b0;
    end
    else
    begin
        if (regWr && (regAddr == `OFS_SOURCE))
            source_r <= regWdata;
        if (regWr && (regAddr == `OFS_LENGTH))
            length_r <= regWdata;
        // command effects land at the edge that takes the command write
        result_r <= resultNxt;
        bitFifoStore_r <= bitFifoNxt;
        wrPtr_r <= wrPtrNxt;
        shifterSignFlag <= signNxt;
        shifterZeroFlag <= zeroNxt;
        shifterOverflowFlag <= ovfNxt;
        fifoFillFlag <= fillNxt;
    end
end

// ----------------------------------------------------------------
// read port
// ----------------------------------------------------------------
// read data stand for one cycle only, zero otherwise and for holes
always @(posedge mclk or negedge rstSync_r)
begin
    if (!rstSync_r)
        regRdata <= 32'h00000000;
    else if (regRd)
    begin
        case (regAddr)
            `OFS_SOURCE: regRdata <= source_r;
            `OFS_LENGTH: regRdata <= length_r;
            `OFS_RESULT: regRdata <= result_r;
            `OFS_STATUS: regRdata <= {28'h0000000, fifoFillFlag, shifterOverflowFlag,
                                      shifterZeroFlag, shifterSignFlag};
            `OFS_WRPTR: regRdata <= {25'h0000000, wrPtr_r};
            `OFS_FIFO_HI: regRdata <= bitFifoStore_r[63:32];
            `OFS_FIFO_LO: regRdata <= bitFifoStore_r[31:0];
            default: regRdata <= 32'h00000000;
        endcase
    end
    else
        regRdata <= 32'h00000000;
end

endmodule // shifter_exponent_pack_bitfifo

/* File: shifter_exponent_pack_bitfifo_assertions.sv */
`timescale 1ns/100ps
`include "shifter_bitfifo_regs.vh"
module shifter_exponent_pack_bitfifo_checker (
    input logic mclk,
    input logic rst_n,
    input logic [7:0] regAddr,
    input logic [31:0] regWdata,
    input logic regWr,
    input logic regRd,
    input logic [31:0] regRdata,
    input logic adderOverflowFlag,
    input logic shifterSignFlag,
    input logic shifterZeroFlag,
    input logic shifterOverflowFlag,
    input logic fifoFillFlag
);
    // ------------------------------------------------
    // source sign tracking
    // ------------------------------------------------
    reg srcTop_r;
    // the source register is not a port, so its top bit is shadowed here
    always @(posedge mclk or negedge rst_n)
        if (!rst_n)
            srcTop_r <= 1'b0;
        else if (regWr && regAddr == `OFS_SOURCE)
            srcTop_r <= regWdata[31];

    // ------------------------------------------------
    // flag and read-data properties
    // ------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence cmdOp(logic [2:0] op);
        regWr && regAddr == `OFS_COMMAND && regWdata[2:0] == op;
    endsequence
    sequence noCmd;
        !(regWr && regAddr == `OFS_COMMAND);
    endsequence

    chk_exp_sign: assert property (cmdOp(`OP_EXP_ADDER) |=>
        shifterSignFlag == $past(adderOverflowFlag ^ srcTop_r)) else $error("exp sign flag");
    chk_exp_ovf: assert property (cmdOp(`OP_EXP_ADDER) |=> !shifterOverflowFlag)
        else $error("exp overflow flag");
    chk_lz_flags: assert property (cmdOp(`OP_LEAD_ZEROS) |=>
        !shifterSignFlag && shifterZeroFlag == $past(srcTop_r)) else $error("lz flags");
    chk_lo_flags: assert property (cmdOp(`OP_LEAD_ONES) |=>
        !shifterSignFlag && shifterZeroFlag != $past(srcTop_r)) else $error("lo flags");
    chk_pack_clear: assert property (cmdOp(`OP_PACK) |=>
        !shifterSignFlag && !shifterZeroFlag) else $error("pack flags");
    chk_dep_clear: assert property (cmdOp(`OP_DEPOSIT) |=>
        !shifterSignFlag && !shifterZeroFlag) else $error("deposit flags");
    chk_dep_len: assert property (regWr && regAddr == `OFS_COMMAND &&
        regWdata[2:0] == `OP_DEPOSIT && regWdata[4] && regWdata[21:16] > 6'h20
        |=> shifterOverflowFlag) else $error("deposit length overflow");
    chk_ext_sign: assert property (cmdOp(`OP_EXTRACT) |=> !shifterSignFlag)
        else $error("extract sign flag");
    chk_nu_fill: assert property (regWr && regAddr == `OFS_COMMAND &&
        regWdata[2:0] == `OP_EXTRACT && regWdata[3] |=> $stable(fifoFillFlag))
        else $error("no-update fill changed");
    chk_flags_hold: assert property (noCmd |=> $stable({fifoFillFlag,
        shifterOverflowFlag, shifterZeroFlag, shifterSignFlag})) else $error("flags moved");
    chk_rdata_idle: assert property (!regRd |=> regRdata == 32'h00000000)
        else $error("read data not idle");
endmodule // shifter_exponent_pack_bitfifo_checker

bind shifter_exponent_pack_bitfifo shifter_exponent_pack_bitfifo_checker u_chk (
    .mclk(mclk),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .adderOverflowFlag(adderOverflowFlag),
    .shifterSignFlag(shifterSignFlag),
    .shifterZeroFlag(shifterZeroFlag),
    .shifterOverflowFlag(shifterOverflowFlag),
    .fifoFillFlag(fifoFillFlag)
);

/* File: shifter_exponent_pack_bitfifo_bench.sv */
`timescale 1ns/100ps
`include "shifter_bitfifo_regs.vh"
module shifter_exponent_pack_bitfifo_bench;
    reg mclk;
    reg rst_n;
    reg [7:0] regAddr;
    reg [31:0] regWdata;
    reg regWr;
    reg regRd;
    reg adderOverflowFlag;
    reg [3:0] fMask;
    wire [31:0] regRdata;
    wire [3:0] flags;
    integer failures;
    integer cmpCount;

    shifter_exponent_pack_bitfifo u_dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWr(regWr),
        .regRd(regRd),
        .regRdata(regRdata),
        .adderOverflowFlag(adderOverflowFlag),
        .shifterSignFlag(flags[0]),
        .shifterZeroFlag(flags[1]),
        .shifterOverflowFlag(flags[2]),
        .fifoFillFlag(flags[3])
    );

    // ------------------------------------------------
    // access tasks
    // ------------------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmpCount = cmpCount + 1;
            if (got !== exp)
            begin
                failures = failures + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask

    // one idle cycle after each strobe keeps every signal to one update per step
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            regWr <= 1'b1;
            regAddr <= a;
            regWdata <= d;
            @(posedge mclk);
            regWr <= 1'b0;
        end
    endtask

    task rd(input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            @(posedge mclk);
            regRd <= 1'b1;
            regAddr <= a;
            @(posedge mclk);
            regRd <= 1'b0;
            #1;
            chk(regRdata & m, e);
        end
    endtask

    // source, command, then flags and masked result
    task run(input [31:0] s, input v, input [31:0] c, input [3:0] f, input [31:0] m,
        input [31:0] e);
        begin
            wr(`OFS_SOURCE, s);
            adderOverflowFlag <= v;
            wr(`OFS_COMMAND, c);
            #1;
            chk({28'h0, flags & fMask}, {28'h0, f});
            rd(`OFS_RESULT, m, e);
        end
    endtask

    task end_sim;
        begin
            $display("compares %0d mismatches %0d", cmpCount, failures);
            if (failures == 0 && cmpCount > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // ------------------------------------------------
    // clock and sequence
    // ------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        rst_n = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h00000000;
        regWr = 1'b0;
        regRd = 1'b0;
        adderOverflowFlag = 1'b0;
        fMask = 4'hF;
        failures = 0;
        cmpCount = 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(`OFS_STATUS, 32'hFFFFFFFF, 32'h00000000);
        rd(8'h20, 32'hFFFFFFFF, 32'h00000000);
        run(32'h00010000, 0, 32'h0, 4'h0, 32'hFF, 32'hF2);
        run(32'hFFFF0000, 0, 32'h0, 4'h1, 32'hFF, 32'hF1);
        run(32'h40000000, 0, 32'h0, 4'h2, 32'hFF, 32'h00);
        run(32'h80000000, 1, 32'h0, 4'h0, 32'hFF, 32'h01);
        run(32'h00F00000, 1, 32'h0, 4'h1, 32'hFF, 32'h01);
        run(32'h00000000, 0, 32'h1, 4'h4, 32'h3F, 32'h20);
        run(32'h80000000, 0, 32'h1, 4'h2, 32'h3F, 32'h00);
        run(32'h000FFFFF, 0, 32'h1, 4'h0, 32'h3F, 32'h0C);
        run(32'hFFFFFFFF, 0, 32'h2, 4'h4, 32'h3F, 32'h20);
        run(32'h7FFFFFFF, 0, 32'h2, 4'h2, 32'h3F, 32'h00);
        run(32'hFFF00000, 0, 32'h2, 4'h0, 32'h3F, 32'h0C);
        run(32'h3F800000, 0, 32'h3, 4'h0, 32'hFFFF, 32'h3800);
        run(32'hC0000000, 0, 32'h3, 4'h0, 32'hFFFF, 32'hC000);
        run(32'h3F800800, 0, 32'h3, 4'h0, 32'hFFFF, 32'h3801);
        run(32'h43800000, 0, 32'h3, 4'h0, 32'hFFFF, 32'h7800);
        run(32'h47800000, 0, 32'h3, 4'h0, 32'hFFFF, 32'h7FFF);
        run(32'hC7800000, 0, 32'h3, 4'h0, 32'hFFFF, 32'hFFFF);
        run(32'h3C000000, 0, 32'h3, 4'h0, 32'hFFFF, 32'h0400);
        run(32'h37000000, 0, 32'h3, 4'h0, 32'hFFFF, 32'h0001);
        run(32'h36800000, 0, 32'h3, 4'h0, 32'hFFFF, 32'h0000);
        run(32'h80800000, 0, 32'h3, 4'h0, 32'hFFFF, 32'h8000);
        run(32'h3801, 0, 32'h4, 4'h0, 32'hFFFFFFFF, 32'h3F801000);
        run(32'hC000, 0, 32'h4, 4'h0, 32'hFFFFFFFF, 32'hC0000000);
        run(32'h0003, 0, 32'h4, 4'h0, 32'hFFFFFFFF, 32'h37C00000);
        run(32'h0400, 0, 32'h4, 4'h0, 32'hFFFFFFFF, 32'h3C000000);
        run(32'h0, 0, 32'h7, 4'h0, 32'h0, 32'h0);
        wr(`OFS_LENGTH, 32'h0000000C);
        run(32'hFFFFFABC, 0, 32'h5, 4'h0, 32'h0, 32'h0);
        rd(`OFS_FIFO_HI, 32'hFFFFFFFF, 32'hABC00000);
        rd(`OFS_WRPTR, 32'h7F, 32'h0C);
        run(32'h00123456, 0, 32'h00180015, 4'h8, 32'h0, 32'h0);
        rd(`OFS_FIFO_HI, 32'hFFFFFFFF, 32'hABC12345);
        rd(`OFS_FIFO_LO, 32'hFFFFFFFF, 32'h60000000);
        run(32'h0, 0, 32'h0008001E, 4'h8, 32'hFFFFFFFF, 32'hAB);
        rd(`OFS_WRPTR, 32'h7F, 32'h24);
        run(32'h0, 0, 32'h00080016, 4'h0, 32'hFFFFFFFF, 32'hAB);
        rd(`OFS_FIFO_HI, 32'hFFFFFFFF, 32'hC1234560);
        run(32'h0, 0, 32'h001C0016, 4'h0, 32'hFFFFFFFF, 32'h0C123456);
        run(32'h0, 0, 32'h00000016, 4'h2, 32'hFFFFFFFF, 32'h0);
        fMask = 4'h5;
        run(32'h0, 0, 32'h00040016, 4'h4, 32'h0, 32'h0);
        fMask = 4'h7;
        run(32'h41, 0, 32'h7, 4'h4, 32'h0, 32'h0);
        run(32'h0, 0, 32'h00210015, 4'h4, 32'h0, 32'h0);
        fMask = 4'hF;
        run(32'h40, 0, 32'h7, 4'h8, 32'h0, 32'h0);
        rd(`OFS_STATUS, 32'hFFFFFFFF, 32'h8);
        fMask = 4'h7;
        run(32'h1, 0, 32'h00010015, 4'h4, 32'h0, 32'h0);
        wr(`OFS_RESULT, 32'h12345678);
        rd(`OFS_RESULT, 32'hFFFFFFFF, 32'h00000000);
        rd(`OFS_SOURCE, 32'hFFFFFFFF, 32'h1);
        end_sim;
    end
endmodule // shifter_exponent_pack_bitfifo_bench
